// >>> dv/data_nvm_byte_write_control_tb_top.sv
// Testbench joining host and device over the register port, driven through APB.
`timescale 1ns/1ns
`default_nettype none
module data_nvm_byte_write_control_tb_top;
  logic clk_in = 1'b0; // System clock.
  logic sys_rst_in = 1'b1; // Synchronous reset.
  logic por_in = 1'b1; // Power-on reset.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request.
  logic [7:0] paddr = 8'h00; // APB address.
  logic [31:0] pwdata = 32'h0, prdata; // APB data.
  logic pready, pslverr; // APB answer.
  logic cp = 1'b1, ext_rd = 1'b0, ext_wr = 1'b0, ext_blk, busy; // Programmer port.
  logic [7:0] ext_addr = 8'h00, ext_wdata = 8'h00, ext_rdata; // Programmer data.
  logic [31:0] q; // Last APB read data.
  logic e; // Last APB error.
  int errors = 0;
  int checked = 0;
  logic [15:0] rows [3] = '{16'h005A, 16'hFFA5, 16'h7F00}; // Address and byte pairs.
  nvm_if nif();
  nvm_device #(.DEPTH(256), .WRITE_CYCLES(20), .PWRT_CYCLES(200)) u_nvm_device (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .por_in(por_in), .bus(nif), .code_protect_in(cp), .ext_rd_in(ext_rd),
    .ext_wr_in(ext_wr), .ext_addr_in(ext_addr), .ext_wdata_in(ext_wdata), .ext_rdata_out(ext_rdata),
    .ext_blocked_out(ext_blk), .busy_out(busy));
  nvm_host u_nvm_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .port(nif));
  nvm_checker #(.WC(20), .PW(200)) u_nvm_checker (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .por_in(por_in),
    .wr_en(nif.wr_en), .rd_en(nif.rd_en), .sel(nif.sel), .wdata(nif.wdata), .rdata(nif.rdata),
    .done_flag(nif.done_flag), .done_clr(nif.done_clr));
  // Clock at 100 ns period.
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Issue a command and poll the busy status bit under a bound.
  task automatic cmd(input logic [7:0] a, input logic [1:0] c);
    int n;
    n = 0;
    apb(1'b1, nvm_pkg::OFS_ADDR, {24'h0, a});
    apb(1'b1, nvm_pkg::OFS_CMD, {30'h0, c});
    do begin
      apb(1'b0, nvm_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    chk("command finished", 32'h0, {31'h0, q[0]});
  endtask : cmd
  // Programmer port access; outputs checked once the flops have taken it.
  task automatic ext(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    ext_rd <= r;
    ext_wr <= w;
    ext_addr <= a;
    ext_wdata <= d;
    @(posedge clk_in);
    ext_rd <= 1'b0;
    ext_wr <= 1'b0;
    @(posedge clk_in);
  endtask : ext
  // Print counts and the verdict, then stop.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Cut a hang short.
  initial begin
    repeat (30000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    por_in <= 1'b0;
    repeat (220) @(posedge clk_in);
    // Protected array still written and read by the processor side.
    foreach (rows[i]) begin
      apb(1'b1, nvm_pkg::OFS_WDATA, {24'h0, rows[i][7:0]});
      cmd(rows[i][15:8], nvm_pkg::CMD_WRITE);
      cmd(rows[i][15:8], nvm_pkg::CMD_READ);
      apb(1'b0, nvm_pkg::OFS_RDATA, 32'h0);
      chk("byte", {24'h0, rows[i][7:0]}, {24'h0, q[7:0]});
    end
    $display("table test done");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    ext(1'b1, 1'b0, 8'h00, 8'h00);
    chk("protected read", 32'h100, {23'h0, ext_blk, ext_rdata});
    ext(1'b0, 1'b1, 8'h00, 8'h11);
    chk("protected write blocked", 32'h1, {31'h0, ext_blk});
    cp <= 1'b0;
    ext(1'b1, 1'b0, 8'h00, 8'h00);
    chk("open read", 32'h05A, {23'h0, ext_blk, ext_rdata});
    $display("protect test done");
    // Index change while busy is ignored.
    apb(1'b1, nvm_pkg::OFS_WDATA, 32'h77);
    apb(1'b1, nvm_pkg::OFS_ADDR, 32'h20);
    apb(1'b1, nvm_pkg::OFS_CMD, {30'h0, nvm_pkg::CMD_WRITE});
    apb(1'b1, nvm_pkg::OFS_ADDR, 32'h21);
    // The host needs a few more cycles to reach the start write; the cycle then runs far longer.
    repeat (4) @(posedge clk_in);
    chk("busy", 32'h1, {31'h0, busy});
    cmd(8'h20, nvm_pkg::CMD_READ);
    cmd(8'h20, nvm_pkg::CMD_READ);
    apb(1'b0, nvm_pkg::OFS_RDATA, 32'h0);
    chk("frozen write", 32'h77, {24'h0, q[7:0]});
    $display("busy test done");
    // Writes refused during the power-up timer.
    @(posedge clk_in);
    por_in <= 1'b1;
    @(posedge clk_in);
    por_in <= 1'b0;
    apb(1'b1, nvm_pkg::OFS_WDATA, 32'h33);
    cmd(8'h00, nvm_pkg::CMD_WRITE);
    repeat (220) @(posedge clk_in);
    cmd(8'h00, nvm_pkg::CMD_READ);
    apb(1'b0, nvm_pkg::OFS_RDATA, 32'h0);
    chk("power-up write", 32'h5A, {24'h0, q[7:0]});
    $display("power-up test done");
    report_and_stop();
  end
endmodule : data_nvm_byte_write_control_tb_top
`default_nettype wire

// >>> dv/nvm_checker.sv
// Interface checker for the nonvolatile register port between host and device.
`timescale 1ns/1ns
`default_nettype none
module nvm_checker #(
  parameter int WC = 20,
  parameter int PW = 200
) (
  // Clock, resets and the register port.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic por_in,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic done_flag,
  input wire logic done_clr
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || por_in);
  logic [1:0] ul_q; // Unlock progress seen on the port.
  logic permit_q; // Permit bit last written by the host.
  logic known_q; // Permit bit written since the last reset.
  logic started_q; // A legal start was issued and is running.
  logic done_q; // Completion flag one cycle ago.
  int cnt_q; // Cycles since the running start.
  int pw_q; // Cycles since power-on.
  logic wstart; // This write should start a cycle.
  assign wstart = wr_en && sel == nvm_pkg::SEL_CONTROL && wdata[nvm_pkg::BIT_START] && wdata[7:6] == 2'h0
    && ul_q == 2'h2 && permit_q && known_q && !started_q && pw_q >= PW;
  // Track the two keys; any other write drops the progress.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      ul_q <= 2'h0;
    end else if (wr_en) begin
      ul_q <= (sel == nvm_pkg::SEL_UNLOCK && wdata == nvm_pkg::UNLOCK_KEY1) ? 2'h1 :
        (ul_q == 2'h1 && sel == nvm_pkg::SEL_UNLOCK && wdata == nvm_pkg::UNLOCK_KEY2) ? 2'h2 : 2'h0;
    end
  end
  // Mirror the permit bit; writes during a cycle are ignored by the device.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      permit_q <= 1'b0;
      known_q <= 1'b0;
    end else if (wr_en && sel == nvm_pkg::SEL_CONTROL && !started_q) begin
      permit_q <= wdata[nvm_pkg::BIT_PERMIT];
      known_q <= 1'b1;
    end
  end
  // Running cycle, its length and the completion flag of one cycle ago.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      started_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      started_q <= wstart ? 1'b1 : (done_flag && !done_q) ? 1'b0 : started_q;
      done_q <= done_flag;
      cnt_q <= started_q ? cnt_q + 1 : 0;
    end
  end
  // Power-up age counts from the power-on reset only.
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      pw_q <= 0;
    end else if (pw_q <= PW) begin
      pw_q <= pw_q + 1;
    end
  end
  unlock_reads_zero_a: assert property (rd_en && sel == nvm_pkg::SEL_UNLOCK |=> rdata == 8'h00)
    else $error("unlock port read not zero");
  control_gaps_zero_a: assert property (rd_en && sel == nvm_pkg::SEL_CONTROL |=>
    rdata[5:4] == 2'h0 && !rdata[nvm_pkg::BIT_READ]) else $error("unused control bits not zero");
  done_sticky_a: assert property (done_flag && !done_clr |=> done_flag)
    else $error("done flag dropped without clear");
  done_cause_a: assert property ($rose(done_flag) |-> started_q)
    else $error("done flag without legal unlocked start");
  write_late_a: assert property (cnt_q <= WC + 4)
    else $error("write cycle overran");
  write_early_a: assert property ($rose(done_flag) |-> cnt_q >= WC - 2)
    else $error("write cycle ended early");
  start_refused_a: assert property (rd_en && sel == nvm_pkg::SEL_CONTROL && !started_q |=>
    !rdata[nvm_pkg::BIT_START]) else $error("start bit set without a legal start");
  permit_kept_a: assert property (rd_en && sel == nvm_pkg::SEL_CONTROL && known_q && !started_q |=>
    rdata[nvm_pkg::BIT_PERMIT] == permit_q) else $error("permit bit changed by hardware");
  rdata_held_a: assert property (!rd_en |=> $stable(rdata))
    else $error("read data changed without a read");
  started_c: cover property (wstart);
  done_c: cover property ($rose(done_flag));
  control_read_c: cover property (rd_en && sel == nvm_pkg::SEL_CONTROL);
endmodule : nvm_checker
`default_nettype wire

// >>> rtl/nvm_device.sv
// Data nonvolatile byte array with unlock-guarded self-timed writes.
`timescale 1ns/1ns
`default_nettype none
module nvm_device #(
  parameter int DEPTH = 256,
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES,
  parameter int PWRT_CYCLES = nvm_pkg::PWRT_CYCLES
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic por_in, // Power-on reset, synchronous, active high.
  // Processor side register port.
  nvm_if.device bus,
  // External programmer port.
  input wire logic code_protect_in,
  input wire logic ext_rd_in,
  input wire logic ext_wr_in,
  input wire logic [7:0] ext_addr_in,
  input wire logic [7:0] ext_wdata_in,
  output logic [7:0] ext_rdata_out,
  output logic ext_blocked_out,
  output logic busy_out
);
  logic [7:0] mem [DEPTH]; // Array storage.
  logic [7:0] index_q; // Byte index register.
  logic [7:0] value_q; // Byte value register.
  logic array_q, cfg_q, abort_q, permit_q, start_q; // Control bits.
  logic [7:0] rdata_q; // Registered read data.
  logic done_q; // Completion flag.
  nvm_pkg::unlock_e ul_q; // Unlock tracker.
  logic [31:0] wcnt_q; // Self-timed write counter.
  logic [31:0] pwrt_q; // Power-up timer.
  logic pwrt_busy; // Power-up timer still running.
  logic [7:0] ext_rdata_q;
  logic ext_blocked_q;
  logic ctrl_wr; // Host write to control.
  logic start_req; // Legal start request this cycle.
  logic [7:0] ctrl_view; // Control register as read.

  assign pwrt_busy = (pwrt_q != 32'h0);
  assign ctrl_wr = bus.wr_en && (bus.sel == nvm_pkg::SEL_CONTROL);
  // A start needs unlock armed, permit already set, and no running timers.
  assign start_req = ctrl_wr && bus.wdata[nvm_pkg::BIT_START] && !start_q && (ul_q == nvm_pkg::UL_ARMED)
    && permit_q
    && !pwrt_busy
    && !array_q && !cfg_q;
  // Bit 5 and bit 4 read as zero in this controller.
  assign ctrl_view = {array_q, cfg_q, 2'b00, abort_q, permit_q, start_q, 1'b0};

  // Power-up timer counts down from power-on only.
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      pwrt_q <= 32'(PWRT_CYCLES);
    end else if (pwrt_busy) begin
      pwrt_q <= pwrt_q - 32'h1;
    end
  end

  // Unlock tracker: a first-key write always moves it to key one; any other write but the expected second key returns it to idle.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      ul_q <= nvm_pkg::UL_IDLE;
    end else if (bus.wr_en) begin
      if (bus.sel == nvm_pkg::SEL_UNLOCK && bus.wdata == nvm_pkg::UNLOCK_KEY1) begin
        ul_q <= nvm_pkg::UL_KEY1;
      end else if (bus.sel == nvm_pkg::SEL_UNLOCK && bus.wdata == nvm_pkg::UNLOCK_KEY2 && ul_q == nvm_pkg::UL_KEY1) begin
        ul_q <= nvm_pkg::UL_ARMED;
      end else begin
        ul_q <= nvm_pkg::UL_IDLE;
      end
    end
  end

  // Index and value registers; frozen while a write runs.
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      index_q <= nvm_pkg::RESET_BYTE;
      value_q <= nvm_pkg::RESET_BYTE;
    end else if (bus.wr_en && !start_q) begin
      if (bus.sel == nvm_pkg::SEL_INDEX) begin
        index_q <= bus.wdata;
      end else if (bus.sel == nvm_pkg::SEL_VALUE) begin
        value_q <= bus.wdata;
      end else if (ctrl_wr && bus.wdata[nvm_pkg::BIT_READ] && !bus.wdata[nvm_pkg::BIT_ARRAY]
                   && !bus.wdata[nvm_pkg::BIT_CFG]) begin
        value_q <= mem[index_q];
      end
    end
  end

  // Control bits other than start.
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      permit_q <= 1'b0;
      array_q <= 1'b0;
      cfg_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (sys_rst_in) begin
      // Reset mid-write flags an abort; select bits kept for tracing.
      permit_q <= 1'b0;
      if (start_q) begin
        abort_q <= 1'b1;
      end
    end else if (ctrl_wr && !start_q) begin
      permit_q <= bus.wdata[nvm_pkg::BIT_PERMIT];
      array_q <= bus.wdata[nvm_pkg::BIT_ARRAY];
      cfg_q <= bus.wdata[nvm_pkg::BIT_CFG];
      if (bus.wdata[nvm_pkg::BIT_START] && !start_req) begin
        abort_q <= 1'b1;
      end else begin
        abort_q <= bus.wdata[nvm_pkg::BIT_ABORT];
      end
    end
  end

  // Start bit and self-timed write cycle.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      start_q <= 1'b0;
      wcnt_q <= 32'h0;
    end else if (start_req) begin
      start_q <= 1'b1;
      wcnt_q <= 32'(WRITE_CYCLES);
    end else if (start_q) begin
      if (wcnt_q == 32'h1) begin
        start_q <= 1'b0;
      end
      wcnt_q <= wcnt_q - 32'h1;
    end
  end

  // Array update from the processor at cycle end, or from the programmer.
  always_ff @(posedge clk_in) begin
    if (start_q && wcnt_q == 32'h1) begin
      mem[index_q] <= value_q;
    end else if (ext_wr_in && !code_protect_in && !start_q) begin
      mem[ext_addr_in] <= ext_wdata_in;
    end
  end

  // Completion flag; set wins over clear.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      done_q <= 1'b0;
    end else if (start_q && wcnt_q == 32'h1) begin
      done_q <= 1'b1;
    end else if (bus.done_clr) begin
      done_q <= 1'b0;
    end
  end

  // Register read data.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      rdata_q <= 8'h00;
    end else if (bus.rd_en) begin
      if (bus.sel == nvm_pkg::SEL_INDEX) begin
        rdata_q <= index_q;
      end else if (bus.sel == nvm_pkg::SEL_VALUE) begin
        rdata_q <= value_q;
      end else if (bus.sel == nvm_pkg::SEL_CONTROL) begin
        rdata_q <= ctrl_view;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // External programmer read path, blocked under code protect.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || por_in) begin
      ext_rdata_q <= 8'h00;
      ext_blocked_q <= 1'b0;
    end else begin
      ext_blocked_q <= code_protect_in && (ext_rd_in || ext_wr_in);
      if (ext_rd_in) begin
        ext_rdata_q <= code_protect_in ? 8'h00 : mem[ext_addr_in];
      end
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.done_flag = done_q;
  assign ext_rdata_out = ext_rdata_q;
  assign ext_blocked_out = ext_blocked_q;
  assign busy_out = start_q;
endmodule : nvm_device
`default_nettype wire

// >>> rtl/nvm_host.sv
// APB-controlled sequencer that drives the nonvolatile register port as firmware would.
`timescale 1ns/1ns
`default_nettype none
module nvm_host (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Device port.
  nvm_if.host port
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0000, H_IDX = 4'b0001, H_VAL = 4'b0010, H_PERMIT = 4'b0011,
    H_K1 = 4'b0100, H_K2 = 4'b0101, H_GO = 4'b0110, H_WAIT = 4'b0111,
    H_OFF = 4'b1000, H_RD = 4'b1001, H_RDV = 4'b1010, H_RDW = 4'b1011, H_GETV = 4'b1100
  } host_e;
  host_e st_q; // Sequencer state.
  logic [7:0] addr_q, wdata_q, rdata_q; // Command registers.
  logic err_q; // Last command ended in abort.
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic wr_q, rd_q, clr_q;
  logic [1:0] sel_q;
  logic [7:0] pw_q;
  logic access; // APB access phase, answered next cycle.
  logic commit; // Access phase at the edge where pready is seen high; writes land only here.
  logic rd_seen_q; // Read strobe one cycle ago; port read data is fresh while it is high.

  assign access = psel_in && penable_in && !pready_q;
  assign commit = psel_in && penable_in && pready_q;

  // APB slave: one wait state; read data is prepared in the wait state, unmapped addresses flag an error.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= access;
      pslverr_q <= 1'b0;
      if (access) begin
        prdata_q <= 32'h0;
        if (paddr_in == nvm_pkg::OFS_ADDR) begin
          prdata_q <= {24'h0, addr_q};
        end else if (paddr_in == nvm_pkg::OFS_WDATA) begin
          prdata_q <= {24'h0, wdata_q};
        end else if (paddr_in == nvm_pkg::OFS_STATUS) begin
          prdata_q <= {29'h0, err_q, port.done_flag, st_q != H_IDLE};
        end else if (paddr_in == nvm_pkg::OFS_RDATA) begin
          prdata_q <= {24'h0, rdata_q};
        end else if (paddr_in != nvm_pkg::OFS_CMD) begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  // Address and data command registers.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
    end else if (commit && pwrite_in && st_q == H_IDLE) begin
      if (paddr_in == nvm_pkg::OFS_ADDR) begin
        addr_q <= pwdata_in[7:0];
      end else if (paddr_in == nvm_pkg::OFS_WDATA) begin
        wdata_q <= pwdata_in[7:0];
      end
    end
  end

  // Sequencer: index, value, permit, unlock keys back to back, start, wait, permit off.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= H_IDLE;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      clr_q <= 1'b0;
      sel_q <= nvm_pkg::SEL_INDEX;
      pw_q <= 8'h00;
      rdata_q <= 8'h00;
      err_q <= 1'b0;
      rd_seen_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      clr_q <= 1'b0;
      // The port answers a read strobe one edge later, so the data is used one edge after that.
      rd_seen_q <= rd_q;
      case (st_q)
        H_IDLE: begin
          if (commit && pwrite_in && paddr_in == nvm_pkg::OFS_CMD && pwdata_in[1:0] != 2'h0) begin
            st_q <= (pwdata_in[1:0] == nvm_pkg::CMD_WRITE) ? H_IDX : H_RD;
            clr_q <= 1'b1;
          end
        end
        H_IDX, H_RD: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_INDEX; pw_q <= addr_q;
          st_q <= (st_q == H_RD) ? H_RDV : H_VAL;
        end
        H_VAL: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_VALUE; pw_q <= wdata_q;
          st_q <= H_PERMIT;
        end
        H_PERMIT: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_CONTROL; pw_q <= 8'h04;
          st_q <= H_K1;
        end
        H_K1: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_UNLOCK; pw_q <= nvm_pkg::UNLOCK_KEY1;
          st_q <= H_K2;
        end
        H_K2: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_UNLOCK; pw_q <= nvm_pkg::UNLOCK_KEY2;
          st_q <= H_GO;
        end
        H_GO: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_CONTROL; pw_q <= 8'h06;
          st_q <= H_WAIT;
        end
        H_WAIT: begin
          // Poll the control register for abort and the done flag.
          rd_q <= 1'b1; sel_q <= nvm_pkg::SEL_CONTROL;
          if (port.done_flag) begin
            clr_q <= 1'b1; err_q <= 1'b0; st_q <= H_OFF;
          end else if (rd_seen_q && port.rdata[nvm_pkg::BIT_ABORT]) begin
            err_q <= 1'b1; st_q <= H_OFF;
          end
        end
        H_OFF: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_CONTROL; pw_q <= 8'h00;
          st_q <= H_IDLE;
        end
        H_RDV: begin
          wr_q <= 1'b1; sel_q <= nvm_pkg::SEL_CONTROL; pw_q <= 8'h01;
          st_q <= H_RDW;
        end
        H_RDW: begin
          rd_q <= 1'b1; sel_q <= nvm_pkg::SEL_VALUE;
          st_q <= H_GETV;
        end
        H_GETV: begin
          // Wait until the value read has reached the port; stale data would be taken otherwise.
          if (rd_seen_q) begin
            rdata_q <= port.rdata; err_q <= 1'b0;
            st_q <= H_IDLE;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign port.wr_en = wr_q;
  assign port.rd_en = rd_q;
  assign port.sel = sel_q;
  assign port.wdata = pw_q;
  assign port.done_clr = clr_q;
endmodule : nvm_host
`default_nettype wire

// >>> shared/nvm_if.sv
// Special register port joining the processor-side host to the nonvolatile controller.
`timescale 1ns/1ns
`default_nettype none
interface nvm_if;
  logic wr_en; // One-cycle register write strobe.
  logic rd_en; // One-cycle register read strobe.
  logic [1:0] sel; // Register select.
  logic [7:0] wdata; // Write data.
  logic [7:0] rdata; // Read data, registered, valid the cycle after rd_en.
  logic done_flag; // Completion flag level.
  logic done_clr; // One-cycle clear of the completion flag.
  modport device (input wr_en, rd_en, sel, wdata, done_clr, output rdata, done_flag);
  modport host (output wr_en, rd_en, sel, wdata, done_clr, input rdata, done_flag);
endinterface : nvm_if
`default_nettype wire

// >>> shared/nvm_pkg.sv
// Shared constants and types for the data nonvolatile byte controller and its host end.
package nvm_pkg;
  // Register selects on the device's own special register port.
  localparam logic [1:0] SEL_INDEX = 2'h0;
  localparam logic [1:0] SEL_VALUE = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_UNLOCK = 2'h3;
  // Control register bit positions.
  localparam int BIT_READ = 0;
  localparam int BIT_START = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_ABORT = 3;
  localparam int BIT_CFG = 6;
  localparam int BIT_ARRAY = 7;
  // Unlock key values.
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  // Clock rate and timing.
  localparam int CLK_HZ = 10000000;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_HZ / 1000000);
  localparam int PWRT_TIME_US = 65000;
  localparam int PWRT_CYCLES = PWRT_TIME_US * (CLK_HZ / 1000000);
  // Values after reset.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // APB register offsets of the host controller.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  // Host command codes.
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  // Unlock tracking states.
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_ARMED = 2'b10
  } unlock_e;
endpackage : nvm_pkg
